// [design/seq_pkg.sv]
// Purpose: Shared constants for the cell and auxiliary conversion sequencer.
// Assumes: A 250 MHz clock; times become counts of 4 ns cycles.
// Notes:   Channel indices run from cell 6 down to cell 1, then aux 1 up to aux 6.
//
// Contract
// - Results are 12-bit unsigned straight-binary codes over 4096 equal steps.
// - Cell channel codes span 1 V to 5 V differential, 976 uV per step.
// - Auxiliary channel codes span 0 V to 5 V single-ended, 1.22 mV per step.
// - A burst starts on a convert-start pin fall or a serial convert command.
// - One start converts every selected channel with no further host action.
// - The first measurement of a burst is always cell 6, tap 6 minus tap 5; select 11 starts on the self-test channel instead.
// - Each end of conversion moves the mux on, acquires, then starts again.
// - Cells go 6 down to 1, then aux channels go upward from aux 1.
// - After the last conversion the mux returns to cell 6 and acquires it.
// - Two-bit select: all twelve, cells plus odd aux, cells only, self-test.
// - Every channel step, acquisition plus conversion, lasts at least 1 us.
// - Select 00 yields twelve conversions; select 10 yields six.
// - Results become readable only after the whole burst has completed.
// - Acquisition defaults to 400 ns, selectable in 400 ns steps to 1.6 us.
// - Averaging repeats all conversions of one channel before the next one.
package seq_pkg;

    // Timing figures and their cycle counts.
    localparam int CLK_PERIOD_NS        = 4;
    localparam int ACQ_STEP_NS          = 400;
    localparam int ACQ_STEP_CYCLES      = (ACQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_MIN_NS          = 1000;
    localparam int STEP_MIN_CYCLES      = (STEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READBACK_WAIT_NS     = 5000;
    localparam int READBACK_WAIT_CYCLES = (READBACK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Conversion code format and input spans.
    localparam int CODE_WIDTH           = 12;
    localparam int CODE_STEPS           = 4096;
    localparam int CELL_LSB_UV          = 976;
    localparam int AUX_LSB_UV_X100      = 122000;
    localparam int CELL_SPAN_LOW_MV     = 1000;
    localparam int CELL_SPAN_HIGH_MV    = 5000;
    localparam int AUX_SPAN_LOW_MV      = 0;
    localparam int AUX_SPAN_HIGH_MV     = 5000;

    // Counter and accumulator widths.
    localparam int TIMER_WIDTH          = 11;
    localparam int ACC_WIDTH            = 15;
    localparam int CH_WIDTH             = 4;

    // Channel indices as driven onto the mux select.
    localparam logic [3:0] CH_CELL6     = 4'h0;
    localparam logic [3:0] CH_CELL1     = 4'h5;
    localparam logic [3:0] CH_AUX_INPUT_FIRST      = 4'h6;
    localparam logic [3:0] CH_AUX5      = 4'hA;
    localparam logic [3:0] CH_AUX6      = 4'hB;
    localparam logic [3:0] CH_SELF_TEST = 4'hC;

    // Channel-select field encodings.
    localparam logic [1:0] SEL_ALL      = 2'h0;
    localparam logic [1:0] SEL_ODD_AUX  = 2'h1;
    localparam logic [1:0] SEL_CELLS    = 2'h2;
    localparam logic [1:0] SEL_SELF     = 2'h3;

    // Power-up acquisition and averaging settings.
    localparam logic [1:0] ACQ_SEL_RESET = 2'h0;
    localparam logic [1:0] AVG_SEL_RESET = 2'h0;

endpackage

// [design/pin_edge_filter.sv]
// Purpose: Bring an outside level into sys_clk and report its filtered edges.
// Assumes: The input is asynchronous to sys_clk.
// Notes:   A change is accepted only when the second and third stages agree.
`timescale 1ns/100ps
module pin_edge_filter #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic sys_clk,       // System clock.
    input  wire logic rst,           // Asynchronous reset, active high.
    input  wire logic pin_in,        // Raw outside level.
    output logic      level,         // Filtered level.
    output logic      rise,          // One-cycle pulse on an accepted rise.
    output logic      fall           // One-cycle pulse on an accepted fall.
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_level;
    logic next_rise;
    logic next_fall;

    // Accept a new level only once the last two stages agree.
    always_comb
    begin
        next_level = level;
        next_rise  = 1'b0;
        next_fall  = 1'b0;
        if (stage2 == stage3 && stage3 != level)
        begin
            next_level = stage3;
            next_rise  = stage3;
            next_fall  = ~stage3;
        end
    end

    // Three-stage chain and registered edge pulses.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
            level  <= RESET_LEVEL;
            rise   <= 1'b0;
            fall   <= 1'b0;
        end
        else
        begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
            rise   <= next_rise;
            fall   <= next_fall;
        end
    end

endmodule // pin_edge_filter

// [design/code_averager.sv]
// Purpose: Sum repeated conversions of one channel and publish the mean.
// Assumes: The sequencer marks the last sample of each channel.
// Notes:   The mean is a plain right shift, so it truncates toward zero.
`timescale 1ns/100ps
module code_averager (
    input  wire logic        sys_clk,        // System clock.
    input  wire logic        rst,            // Asynchronous reset, active high.
    input  wire logic        sample_valid,   // One-cycle pulse with a new code.
    input  wire logic        sample_last,    // Marks the last repeat of a channel.
    input  wire logic [11:0] sample_code,    // Raw converter code.
    input  wire logic [3:0]  sample_channel, // Channel of the code.
    input  wire logic [1:0]  avg_shift,      // Log2 of the repeat count.
    output logic             result_valid,   // One-cycle pulse with a mean.
    output logic [11:0]      result_code,    // Averaged straight-binary code.
    output logic [3:0]       result_channel  // Channel of the mean.
);

    logic [seq_pkg::ACC_WIDTH-1:0] acc;
    logic [seq_pkg::ACC_WIDTH-1:0] next_acc;
    logic [seq_pkg::ACC_WIDTH-1:0] sum;
    logic                          next_valid;
    logic [11:0]                   next_code;
    logic [3:0]                    next_channel;

    // Running sum; the last sample shifts it down and restarts it.
    always_comb
    begin
        sum          = acc + {3'h0, sample_code};
        next_acc     = acc;
        next_valid   = 1'b0;
        next_code    = result_code;
        next_channel = result_channel;
        if (sample_valid)
        begin
            next_acc = sum;
            if (sample_last)
            begin
                next_acc     = '0;
                next_valid   = 1'b1;
                next_code    = 12'(sum >> avg_shift);
                next_channel = sample_channel;
            end
        end
    end

    // Register the sum and the published result.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            acc            <= '0;
            result_valid   <= 1'b0;
            result_code    <= 12'h000;
            result_channel <= 4'h0;
        end
        else
        begin
            acc            <= next_acc;
            result_valid   <= next_valid;
            result_code    <= next_code;
            result_channel <= next_channel;
        end
    end

endmodule // code_averager

// [design/cell_aux_conversion_sequencer.sv]
// Purpose: Run one burst of conversions over the cell and auxiliary inputs.
// Assumes: The core answers sar_start with sar_done and a held code.
// Notes:   Select fields are latched at the start; changes mid-burst take no effect.
`timescale 1ns/100ps
module cell_aux_conversion_sequencer (
    input  wire logic        sys_clk,         // System clock, 250 MHz.
    input  wire logic        rst,             // Asynchronous reset, active high.
    input  wire logic        convert_start_n, // Convert-start pin, active low.
    input  wire logic        serial_convert,  // Serial convert command pulse.
    input  wire logic [1:0]  chan_select,     // Channel-select field.
    input  wire logic [1:0]  acq_select,      // Acquisition-time field.
    input  wire logic [1:0]  avg_select,      // Averaging field, 1/2/4/8.
    input  wire logic        sar_done,        // Converter end of conversion, level.
    input  wire logic [11:0] sar_code,        // Converter code, held with sar_done.
    output logic [3:0]       mux_index,       // Selected input channel.
    output logic             acquiring,       // Sampling the selected input.
    output logic             sar_start,       // One-cycle converter start.
    output logic             burst_busy,      // Burst in progress.
    output logic             burst_done,      // One-cycle pulse at burst end.
    output logic             results_ready,   // Readback wait has elapsed.
    output logic             result_valid,    // One-cycle pulse with a result.
    output logic [11:0]      result_code,     // Straight-binary result.
    output logic [3:0]       result_channel   // Channel of the result.
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ,
        ST_CONV,
        ST_HOLD
    } seq_state_t;

    seq_state_t                      state;
    seq_state_t                      next_state;
    logic [3:0]                      next_mux_index;
    logic                            next_acquiring;
    logic                            next_sar_start;
    logic                            next_burst_busy;
    logic                            next_burst_done;
    logic [1:0]                      mode;
    logic [1:0]                      next_mode;
    logic [1:0]                      acq_sel;
    logic [1:0]                      next_acq_sel;
    logic [1:0]                      avg_sel;
    logic [1:0]                      next_avg_sel;
    logic [2:0]                      repeat_cnt;
    logic [2:0]                      next_repeat_cnt;
    logic [seq_pkg::TIMER_WIDTH-1:0] timer;
    logic [seq_pkg::TIMER_WIDTH-1:0] next_timer;
    logic [seq_pkg::TIMER_WIDTH-1:0] acq_len;
    logic [seq_pkg::TIMER_WIDTH-1:0] wait_cnt;
    logic [seq_pkg::TIMER_WIDTH-1:0] next_wait_cnt;
    logic                            next_results_ready;
    logic                            start_pin_level;
    logic                            start_pin_fall;
    logic                            done_level;
    logic                            done_rise;
    logic                            start_req;
    logic                            sample_valid;
    logic                            sample_last;
    logic                            repeat_last;
    logic [4:0]                      step;

    localparam logic [seq_pkg::TIMER_WIDTH-1:0] ACQ_STEP =
        seq_pkg::TIMER_WIDTH'(seq_pkg::ACQ_STEP_CYCLES);
    localparam logic [seq_pkg::TIMER_WIDTH-1:0] STEP_MIN =
        seq_pkg::TIMER_WIDTH'(seq_pkg::STEP_MIN_CYCLES);
    localparam logic [seq_pkg::TIMER_WIDTH-1:0] RB_WAIT =
        seq_pkg::TIMER_WIDTH'(seq_pkg::READBACK_WAIT_CYCLES);

    // Next channel of the burst: valid bit on top, index below.
    function automatic logic [4:0] next_channel(input logic [3:0] cur, input logic [1:0] sel);
        logic [4:0] res;
        res = {1'b0, cur};
        case (sel)
            seq_pkg::SEL_ALL:
            begin
                if (cur < seq_pkg::CH_AUX6)
                    res = {1'b1, 4'(cur + 4'h1)};
            end
            seq_pkg::SEL_ODD_AUX:
            begin
                if (cur < seq_pkg::CH_CELL1)
                    res = {1'b1, 4'(cur + 4'h1)};
                else if (cur == seq_pkg::CH_CELL1)
                    res = {1'b1, seq_pkg::CH_AUX_INPUT_FIRST};
                else if (cur < seq_pkg::CH_AUX5)
                    res = {1'b1, 4'(cur + 4'h2)};
            end
            seq_pkg::SEL_CELLS:
            begin
                if (cur < seq_pkg::CH_CELL1)
                    res = {1'b1, 4'(cur + 4'h1)};
            end
            default:
            begin
                res = {1'b0, cur};
            end
        endcase
        return res;
    endfunction

    // Filtered convert-start pin; a falling edge is a request.
    pin_edge_filter #(
        .RESET_LEVEL (1'b1)
    ) u_start_filter (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  (convert_start_n),
        .level   (start_pin_level),
        .rise    (),
        .fall    (start_pin_fall)
    );

    // Filtered end of conversion from the converter core.
    pin_edge_filter #(
        .RESET_LEVEL (1'b0)
    ) u_done_filter (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  (sar_done),
        .level   (done_level),
        .rise    (done_rise),
        .fall    ()
    );

    // Averaging of repeated codes and publication of results.
    code_averager u_averager (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .sample_valid   (sample_valid),
        .sample_last    (sample_last),
        .sample_code    (sar_code),
        .sample_channel (mux_index),
        .avg_shift      (avg_sel),
        .result_valid   (result_valid),
        .result_code    (result_code),
        .result_channel (result_channel)
    );

    // Either start source opens a burst while idle.
    assign start_req   = start_pin_fall | serial_convert;
    assign acq_len     = seq_pkg::TIMER_WIDTH'(ACQ_STEP * {9'h000, acq_sel}) + ACQ_STEP;
    assign repeat_last = (repeat_cnt == 3'(({2'h0, 1'b1} << avg_sel) - 3'h1));
    assign step        = next_channel(mux_index, mode);
    assign sample_valid = (state == ST_CONV) && done_rise;
    assign sample_last  = repeat_last;

    // Burst sequencing: acquire, convert, hold out the step minimum, move on.
    always_comb
    begin
        next_state         = state;
        next_mux_index     = mux_index;
        next_acquiring     = acquiring;
        next_sar_start     = 1'b0;
        next_burst_busy    = burst_busy;
        next_burst_done    = 1'b0;
        next_mode          = mode;
        next_acq_sel       = acq_sel;
        next_avg_sel       = avg_sel;
        next_repeat_cnt    = repeat_cnt;
        next_timer         = timer;
        if (timer != '1)
            next_timer = timer + 1'b1;
        case (state)
            ST_IDLE:
            begin
                next_acquiring = 1'b1;
                next_timer     = '0;
                if (start_req)
                begin
                    next_mode       = chan_select;
                    next_acq_sel    = acq_select;
                    next_avg_sel    = avg_select;
                    next_repeat_cnt = 3'h0;
                    next_burst_busy = 1'b1;
                    next_state      = ST_ACQ;
                    if (chan_select == seq_pkg::SEL_SELF)
                        next_mux_index = seq_pkg::CH_SELF_TEST;
                    else
                        next_mux_index = seq_pkg::CH_CELL6;
                end
            end
            ST_ACQ:
            begin
                if (timer >= acq_len - 1'b1)
                begin
                    next_acquiring = 1'b0;
                    next_sar_start = 1'b1;
                    next_state     = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (done_rise)
                    next_state = ST_HOLD;
            end
            ST_HOLD:
            begin
                if (timer >= STEP_MIN - 1'b1)
                begin
                    next_timer     = '0;
                    next_acquiring = 1'b1;
                    next_state     = ST_ACQ;
                    if (!repeat_last)
                    begin
                        next_repeat_cnt = 3'(repeat_cnt + 3'h1);
                    end
                    else if (step[4])
                    begin
                        next_repeat_cnt = 3'h0;
                        next_mux_index  = step[3:0];
                    end
                    else
                    begin
                        next_repeat_cnt = 3'h0;
                        next_mux_index  = seq_pkg::CH_CELL6;
                        next_state      = ST_IDLE;
                        next_burst_busy = 1'b0;
                        next_burst_done = 1'b1;
                    end
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer state registers.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state      <= ST_IDLE;
            mux_index  <= seq_pkg::CH_CELL6;
            acquiring  <= 1'b1;
            sar_start  <= 1'b0;
            burst_busy <= 1'b0;
            burst_done <= 1'b0;
            mode       <= seq_pkg::SEL_ALL;
            acq_sel    <= seq_pkg::ACQ_SEL_RESET;
            avg_sel    <= seq_pkg::AVG_SEL_RESET;
            repeat_cnt <= 3'h0;
            timer      <= '0;
        end
        else
        begin
            state      <= next_state;
            mux_index  <= next_mux_index;
            acquiring  <= next_acquiring;
            sar_start  <= next_sar_start;
            burst_busy <= next_burst_busy;
            burst_done <= next_burst_done;
            mode       <= next_mode;
            acq_sel    <= next_acq_sel;
            avg_sel    <= next_avg_sel;
            repeat_cnt <= next_repeat_cnt;
            timer      <= next_timer;
        end
    end

    // Readback gate: low from a burst start until the wait after its end.
    always_comb
    begin
        next_wait_cnt      = wait_cnt;
        next_results_ready = results_ready;
        if (state == ST_IDLE && start_req)
        begin
            next_results_ready = 1'b0;
            next_wait_cnt      = '0;
        end
        else if (next_burst_done)
        begin
            next_wait_cnt = RB_WAIT;
        end
        else if (wait_cnt != '0)
        begin
            next_wait_cnt = wait_cnt - 1'b1;
            if (wait_cnt == 11'h001)
                next_results_ready = 1'b1;
        end
    end

    // Readback gate registers.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_cnt      <= '0;
            results_ready <= 1'b0;
        end
        else
        begin
            wait_cnt      <= next_wait_cnt;
            results_ready <= next_results_ready;
        end
    end

endmodule // cell_aux_conversion_sequencer

// [dv/seq_port_properties.sv]
// Purpose: Port-level checks of the conversion sequencer.
// Assumes: One sys_clk domain; rst asynchronous, active high.
// Notes:   Counters time acquisition, step spacing and the readback wait.
`timescale 1ns/100ps
module seq_port_checker (
    input wire logic       sys_clk,        // System clock.
    input wire logic       rst,            // Reset, active high.
    input wire logic       serial_convert, // Serial start pulse.
    input wire logic [1:0] chan_select,    // Channel-select field.
    input wire logic [3:0] mux_index,      // Selected channel.
    input wire logic       acquiring,      // Sampling flag.
    input wire logic       sar_start,      // Converter start.
    input wire logic       burst_busy,     // Burst in progress.
    input wire logic       burst_done,     // Burst end pulse.
    input wire logic       results_ready,  // Readback allowed.
    input wire logic       result_valid    // Result pulse.
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    int acq_cnt, step_cnt, wait_cnt;

    // Idle counts park high so no check fires outside a burst.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            acq_cnt <= 0;
            step_cnt <= 5000;
            wait_cnt <= 5000;
        end
        else
        begin
            acq_cnt <= acquiring ? acq_cnt + 1 : 0;
            step_cnt <= sar_start ? 0 : (burst_busy ? step_cnt + 1 : 5000);
            wait_cnt <= burst_done ? 0 : (wait_cnt < 5000 ? wait_cnt + 1 : 5000);
        end
    end

    // Burst end: busy has just dropped.
    sequence s_burst_end;
        !burst_busy && $past(burst_busy);
    endsequence
    // No second result close behind the first.
    sequence s_quiet;
        !result_valid [*8];
    endsequence

    a_start_taken: assert property (!burst_busy && serial_convert |=> burst_busy)
        else $error("start not taken");
    a_first_channel: assert property ($rose(burst_busy) |->
        mux_index == (($past(chan_select) == 2'h3) ? 4'hC : 4'h0))
        else $error("wrong first channel");
    a_acq_length: assert property (sar_start |-> acq_cnt >= 99)
        else $error("acquisition too short");
    a_step_spacing: assert property (sar_start |-> step_cnt >= 249)
        else $error("step too short");
    a_done_parks: assert property (burst_done |-> s_burst_end ##0
        (mux_index == 4'h0 && acquiring))
        else $error("no park on cell 6");
    a_ready_wait: assert property ($rose(results_ready) |->
        wait_cnt >= 1248 && wait_cnt <= 1251)
        else $error("readback wait not 5 us");
    a_ready_bound: assert property (wait_cnt == 1260 && !burst_busy |-> results_ready)
        else $error("ready too late");
    a_start_clears: assert property ($rose(burst_busy) |-> !results_ready)
        else $error("results ready during burst");
    a_result_pulse: assert property (result_valid |-> burst_busy ##1 s_quiet)
        else $error("bad result pulse");
endmodule // seq_port_checker

bind cell_aux_conversion_sequencer seq_port_checker chk_u (.*);

// [dv/sar_core_model.sv]
// Purpose: Behavioural converter core answering the sequencer.
// Assumes: Starts arrive as one-cycle sar_start pulses.
// Notes:   Code is {channel, 8'h40} plus the repeat number.
`timescale 1ns/100ps
module sar_core_model (
    input  wire logic       sys_clk,    // System clock.
    input  wire logic       rst,        // Reset, active high.
    input  wire logic       sar_start,  // Conversion start pulse.
    input  wire logic [3:0] mux_index,  // Channel being converted.
    input  wire logic       burst_busy, // Burst in progress.
    input  wire logic [7:0] conv_len,   // Conversion length in cycles.
    output logic            sar_done,   // End of conversion level.
    output logic [11:0]     sar_code    // Code, held while sar_done is high.
);
    logic [3:0] last_idx;
    logic [3:0] idx;
    logic [2:0] rep;

    // Idle code starts all ones and is the inverse of the last code after each conversion, never a fresh value.
    initial
    begin
        sar_done = 1'b0;
        sar_code = 12'hFFF;
        last_idx = 4'hF;
        rep = 3'h0;
    end

    // One conversion per start, conv_len cycles long.
    always
    begin
        @(posedge sys_clk) #1;
        if (burst_busy !== 1'b1)
            last_idx = 4'hF;
        if (sar_start === 1'b1 && rst === 1'b0)
        begin
            idx = mux_index;
            rep = (idx == last_idx) ? rep + 3'h1 : 3'h0;
            last_idx = idx;
            repeat (conv_len) @(posedge sys_clk) #1;
            sar_code = {idx, 8'h40} + {9'h000, rep};
            sar_done = 1'b1;
            repeat (8) @(posedge sys_clk) #1;
            sar_done = 1'b0;
            sar_code = ~sar_code;
        end
    end
endmodule // sar_core_model

// [dv/test_cell_aux_conversion_sequencer.sv]
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Model codes fix each averaged result.
`timescale 1ns/100ps
module test_cell_aux_conversion_sequencer;
    logic        sys_clk, rst, convert_start_n, serial_convert, sar_done, sar_start;
    logic [1:0]  chan_select, acq_select, avg_select;
    logic [11:0] sar_code, result_code;
    logic [3:0]  mux_index, result_channel;
    logic        acquiring, burst_busy, burst_done, results_ready, result_valid;
    logic [7:0]  conv_len;
    int          err_count = 0;
    int          num_checks = 0;

    cell_aux_conversion_sequencer dut_u (.sys_clk(sys_clk), .rst(rst),
        .convert_start_n(convert_start_n), .serial_convert(serial_convert),
        .chan_select(chan_select), .acq_select(acq_select), .avg_select(avg_select),
        .sar_done(sar_done), .sar_code(sar_code), .mux_index(mux_index),
        .acquiring(acquiring), .sar_start(sar_start), .burst_busy(burst_busy),
        .burst_done(burst_done), .results_ready(results_ready),
        .result_valid(result_valid), .result_code(result_code),
        .result_channel(result_channel));
    sar_core_model core_u (.sys_clk(sys_clk), .rst(rst), .sar_start(sar_start),
        .mux_index(mux_index), .burst_busy(burst_busy), .conv_len(conv_len),
        .sar_done(sar_done), .sar_code(sar_code));

    // Free-running 250 MHz clock.
    always #2 sys_clk = ~sys_clk;

    // Compares a seen value with its expectation.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Prints counts and verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One burst: start, results in order, readback wait.
    task automatic run_burst(input logic [1:0] sel, acq, avg, input bit pin, poke,
                             input logic [7:0] len);
        logic [3:0]  exp_ch[$];
        logic [11:0] ofs;
        int          n, k;
        ofs = 12'(((1 << avg) - 1) >> 1);
        for (k = 0; k < 12; k++)
            if ((sel != 2'h3 && k < 6) || sel == 2'h0 || (sel == 2'h1 && k % 2 == 0))
                exp_ch.push_back(k[3:0]);
        if (sel == 2'h3)
            exp_ch.push_back(4'hC);
        n = (sel != chan_select) ? 22500 : 20;
        chan_select = sel;
        acq_select = acq;
        avg_select = avg;
        conv_len = len;
        repeat (n) @(posedge sys_clk) #1;
        convert_start_n = !pin;
        serial_convert = !pin;
        repeat (pin ? 6 : 1) @(posedge sys_clk) #1;
        convert_start_n = 1'b1;
        serial_convert = 1'b0;
        for (n = 0; burst_busy !== 1'b1 && n < 20; n++)
            @(posedge sys_clk) #1;
        chk(burst_busy, 1'b1);
        chk(results_ready, 1'b0);
        chk(mux_index, exp_ch[0]);
        serial_convert = poke;
        n = 0;
        k = 0;
        do
        begin
            @(posedge sys_clk) #1;
            serial_convert = 1'b0;
            n++;
            if (result_valid === 1'b1)
            begin
                chk(result_channel, exp_ch[k]);
                chk(result_code, {exp_ch[k], 8'h40} + ofs);
                k++;
            end
        end
        while (burst_done !== 1'b1 && n < 40000);
        chk(k, exp_ch.size());
        chk({mux_index, acquiring}, 5'h01);
        for (n = 0; results_ready !== 1'b1 && n < 2000; n++)
            @(posedge sys_clk) #1;
        chk(n >= 1249 && n <= 1251, 1'b1);
    endtask

    // All twelve channels from one serial start.
    task automatic t_all_serial();
        run_burst(2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 8'h64);
    endtask

    // Cells and odd aux from the pin, long acquisition, slow core.
    task automatic t_odd_pin_slow();
        run_burst(2'h1, 2'h3, 2'h0, 1'b1, 1'b0, 8'hC8);
    endtask

    // Cells only, eight repeats each, with a start sent while busy.
    task automatic t_cells_avg();
        run_burst(2'h2, 2'h1, 2'h3, 1'b0, 1'b1, 8'h3C);
    endtask

    // Self-test under every acquisition and averaging code.
    task automatic t_self_test();
        int a;
        for (a = 0; a < 4; a++)
            run_burst(2'h3, a[1:0], a[1:0], 1'b0, 1'b0, 8'h50);
    endtask

    // Cuts a hung run short; a clean run with its select waits is shorter.
    initial
    begin
        #440000;
        err_count++;
        close_out();
    end

    // Reset, then the scenarios.
    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        convert_start_n = 1'b1;
        serial_convert = 1'b0;
        chan_select = 2'h0;
        acq_select = 2'h0;
        avg_select = 2'h0;
        repeat (10) @(posedge sys_clk) #1;
        rst = 1'b0;
        t_all_serial();
        t_odd_pin_slow();
        t_cells_avg();
        t_self_test();
        close_out();
    end
endmodule // test_cell_aux_conversion_sequencer
